//--- core/pilc_pkg.sv
// Constants and register map of the parallel I/O line controller
package pilc_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int LINE_N = 32;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_OUT_SET    = 7'h00;
    localparam logic [ADDR_W-1:0] OFS_OUT_CLR    = 7'h04;
    localparam logic [ADDR_W-1:0] OFS_OUT_LATCH  = 7'h08;
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL  = 7'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN     = 7'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_DIS    = 7'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 7'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT   = 7'h1c;
    localparam logic [ADDR_W-1:0] OFS_OD_EN      = 7'h20;
    localparam logic [ADDR_W-1:0] OFS_OD_DIS     = 7'h24;
    localparam logic [ADDR_W-1:0] OFS_OD_STAT    = 7'h28;
    localparam logic [ADDR_W-1:0] OFS_PU_DIS     = 7'h2c;
    localparam logic [ADDR_W-1:0] OFS_PU_EN      = 7'h30;
    localparam logic [ADDR_W-1:0] OFS_PU_STAT    = 7'h34;
    localparam logic [ADDR_W-1:0] OFS_OWR_EN     = 7'h38;
    localparam logic [ADDR_W-1:0] OFS_OWR_DIS    = 7'h3c;
    localparam logic [ADDR_W-1:0] OFS_OWR_STAT   = 7'h40;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [DATA_W-1:0] LATCH_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MASK_RST   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OD_RST     = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PUDIS_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OWR_RST    = 32'h0000_0000;

    // ************************************************************
    // Bus answers and pin sampling
    // ************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [1:0] PRIME_DONE  = 2'h3;

endpackage : pilc_pkg

//--- core/pilc_top.sv
// Parallel I/O line controller with AXI4-Lite register access
// Functional notes
// - Set-output write: ones force latch bits to 1, zeros leave them.
// - Clear-output write: ones force latch bits to 0, zeros ignored.
// - Output latch status read returns the current latch value.
// - Direct latch write changes only lines with output-write permission.
// - Pin level status read returns synchronized pad levels.
// - Interrupt-enable write: ones set the change mask bit.
// - Interrupt-disable write: ones clear the change mask bit.
// - Mask register reads 1 for enabled, 0 for disabled lines.
// - A detected level change sets the line's status bit.
// - Reading status clears all bits except lines changing in that same cycle; reset clears them too.
// - Open-drain enable write: ones put lines in open-drain mode.
// - Open-drain disable write: ones return lines to push-pull.
// - Open-drain lines drive low only, status reads 1.
// - Push-pull lines drive high and low, status reads 0.
// - Pull-up disable write: ones turn pull-ups off.
// - Pull-up enable write: ones turn pull-ups on.
// - Pull-up status reads 0 when enabled, 1 when disabled.
// - Bit n of every per-line register belongs to line n.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module pilc_top
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // AXI4-Lite write address
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [pilc_pkg::ADDR_W-1:0]   s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    input  wire logic [pilc_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    // AXI4-Lite write response
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output logic [1:0]                         s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    input  wire logic [pilc_pkg::ADDR_W-1:0]   s_axi_araddr,
    // AXI4-Lite read data
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [pilc_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    // Pads
    input  wire logic [pilc_pkg::LINE_N-1:0]   padIn,
    output logic [pilc_pkg::LINE_N-1:0]        padOut,
    output logic [pilc_pkg::LINE_N-1:0]        padOe,
    output logic [pilc_pkg::LINE_N-1:0]        pullEn,
    // Change interrupt
    output logic                               irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [pilc_pkg::LINE_N-1:0] latch;
        logic [pilc_pkg::LINE_N-1:0] imr;
        logic [pilc_pkg::LINE_N-1:0] isr;
        logic [pilc_pkg::LINE_N-1:0] od;
        logic [pilc_pkg::LINE_N-1:0] puDis;
        logic [pilc_pkg::LINE_N-1:0] owr;
        logic [pilc_pkg::LINE_N-1:0] s1;
        logic [pilc_pkg::LINE_N-1:0] s2;
        logic [pilc_pkg::LINE_N-1:0] prev;
        logic [1:0]                  prime;
        logic                        awHeld;
        logic [pilc_pkg::ADDR_W-1:0] awAddr;
        logic                        wHeld;
        logic [pilc_pkg::DATA_W-1:0] wData;
        logic [3:0]                  wStrb;
        logic                        awReady;
        logic                        wReady;
        logic                        bValid;
        logic [1:0]                  bResp;
        logic                        arReady;
        logic                        rValid;
        logic [pilc_pkg::DATA_W-1:0] rData;
        logic [1:0]                  rResp;
        logic [pilc_pkg::LINE_N-1:0] padOut;
        logic [pilc_pkg::LINE_N-1:0] padOe;
        logic [pilc_pkg::LINE_N-1:0] pullEn;
        logic                        irq;
    } pilc_state_t;

    pilc_state_t                 st_r;
    pilc_state_t                 st_nxt;
    logic                        awFire;
    logic                        wFire;
    logic                        arFire;
    logic                        doWrite;
    logic [pilc_pkg::LINE_N-1:0] chg;
    logic [pilc_pkg::DATA_W-1:0] byteMask;
    logic [pilc_pkg::DATA_W-1:0] wrBits;

    // ************************************************************
    // Handshakes and write data masking
    // ************************************************************
    assign awFire  = s_axi_awvalid & st_r.awReady;
    assign wFire   = s_axi_wvalid & st_r.wReady;
    assign arFire  = s_axi_arvalid & st_r.arReady;
    assign doWrite = st_r.awHeld & st_r.wHeld & ~st_r.bValid;

    // Byte enables widened to one mask bit per line
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_strb
            assign byteMask[gi*8 +: 8] = {8{st_r.wStrb[gi]}};
        end
    endgenerate
    assign wrBits = st_r.wData & byteMask;

    // Change seen once the sampling pipe is filled
    assign chg = (st_r.prime == pilc_pkg::PRIME_DONE) ?
                 (st_r.s2 ^ st_r.prev) : '0;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;

        // Pad sampling, first stage read only by the second
        st_nxt.s1   = padIn;
        st_nxt.s2   = st_r.s1;
        st_nxt.prev = st_r.s2;
        if (st_r.prime != pilc_pkg::PRIME_DONE)
        begin
            st_nxt.prime = st_r.prime + 2'h1;
        end

        // Address and data capture, in either order
        if (awFire)
        begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = s_axi_awaddr;
        end
        if (wFire)
        begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = s_axi_wdata;
            st_nxt.wStrb = s_axi_wstrb;
        end
        if (st_r.bValid && s_axi_bready)
        begin
            st_nxt.bValid = 1'b0;
        end

        // Register write, bit n acts on line n
        if (doWrite)
        begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld  = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp  = pilc_pkg::RESP_OKAY;
            case (st_r.awAddr)
                pilc_pkg::OFS_OUT_SET:   st_nxt.latch = st_r.latch | wrBits;
                pilc_pkg::OFS_OUT_CLR:   st_nxt.latch = st_r.latch & ~wrBits;
                pilc_pkg::OFS_OUT_LATCH: st_nxt.latch = (st_r.latch & ~(st_r.owr & byteMask))
                                                      | (wrBits & st_r.owr);
                pilc_pkg::OFS_IRQ_EN:    st_nxt.imr   = st_r.imr | wrBits;
                pilc_pkg::OFS_IRQ_DIS:   st_nxt.imr   = st_r.imr & ~wrBits;
                pilc_pkg::OFS_OD_EN:     st_nxt.od    = st_r.od | wrBits;
                pilc_pkg::OFS_OD_DIS:    st_nxt.od    = st_r.od & ~wrBits;
                pilc_pkg::OFS_PU_DIS:    st_nxt.puDis = st_r.puDis | wrBits;
                pilc_pkg::OFS_PU_EN:     st_nxt.puDis = st_r.puDis & ~wrBits;
                pilc_pkg::OFS_OWR_EN:    st_nxt.owr   = st_r.owr | wrBits;
                pilc_pkg::OFS_OWR_DIS:   st_nxt.owr   = st_r.owr & ~wrBits;
                pilc_pkg::OFS_PIN_LEVEL,
                pilc_pkg::OFS_IRQ_MASK,
                pilc_pkg::OFS_IRQ_STAT,
                pilc_pkg::OFS_OD_STAT,
                pilc_pkg::OFS_PU_STAT,
                pilc_pkg::OFS_OWR_STAT:  st_nxt.bResp = pilc_pkg::RESP_OKAY;
                default:                 st_nxt.bResp = pilc_pkg::RESP_DECERR;
            endcase
        end

        // Read answer
        if (st_r.rValid && s_axi_rready)
        begin
            st_nxt.rValid = 1'b0;
        end
        if (arFire)
        begin
            st_nxt.rValid = 1'b1;
            st_nxt.rResp  = pilc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                pilc_pkg::OFS_OUT_LATCH: st_nxt.rData = st_r.latch;
                pilc_pkg::OFS_PIN_LEVEL: st_nxt.rData = st_r.s2;
                pilc_pkg::OFS_IRQ_MASK:  st_nxt.rData = st_r.imr;
                pilc_pkg::OFS_IRQ_STAT:  st_nxt.rData = st_r.isr;
                pilc_pkg::OFS_OD_STAT:   st_nxt.rData = st_r.od;
                pilc_pkg::OFS_PU_STAT:   st_nxt.rData = st_r.puDis;
                pilc_pkg::OFS_OWR_STAT:  st_nxt.rData = st_r.owr;
                pilc_pkg::OFS_OUT_SET,
                pilc_pkg::OFS_OUT_CLR,
                pilc_pkg::OFS_IRQ_EN,
                pilc_pkg::OFS_IRQ_DIS,
                pilc_pkg::OFS_OD_EN,
                pilc_pkg::OFS_OD_DIS,
                pilc_pkg::OFS_PU_DIS,
                pilc_pkg::OFS_PU_EN,
                pilc_pkg::OFS_OWR_EN,
                pilc_pkg::OFS_OWR_DIS:   st_nxt.rData = '0;
                default:
                begin
                    st_nxt.rData = '0;
                    st_nxt.rResp = pilc_pkg::RESP_DECERR;
                end
            endcase
        end

        // Status: clear on read, a change in the same cycle wins
        if (arFire && (s_axi_araddr == pilc_pkg::OFS_IRQ_STAT))
        begin
            st_nxt.isr = chg;
        end
        else
        begin
            st_nxt.isr = st_r.isr | chg;
        end

        // Channel readies follow the held items
        st_nxt.awReady = ~st_nxt.awHeld & ~st_nxt.bValid;
        st_nxt.wReady  = ~st_nxt.wHeld & ~st_nxt.bValid;
        st_nxt.arReady = ~st_nxt.rValid;

        // Pad drive: open-drain lines only pull low
        st_nxt.padOut = st_nxt.latch & ~st_nxt.od;
        st_nxt.padOe  = ~st_nxt.od | ~st_nxt.latch;
        st_nxt.pullEn = ~st_nxt.puDis;
        st_nxt.irq    = |(st_nxt.isr & st_nxt.imr);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r         <= '0;
            st_r.latch   <= pilc_pkg::LATCH_RST;
            st_r.imr     <= pilc_pkg::MASK_RST;
            st_r.od      <= pilc_pkg::OD_RST;
            st_r.puDis   <= pilc_pkg::PUDIS_RST;
            st_r.owr     <= pilc_pkg::OWR_RST;
            st_r.padOut  <= pilc_pkg::LATCH_RST & ~pilc_pkg::OD_RST;
            st_r.padOe   <= ~pilc_pkg::OD_RST | ~pilc_pkg::LATCH_RST;
            st_r.pullEn  <= ~pilc_pkg::PUDIS_RST;
            st_r.awReady <= 1'b1;
            st_r.wReady  <= 1'b1;
            st_r.arReady <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready = st_r.awReady;
    assign s_axi_wready  = st_r.wReady;
    assign s_axi_bvalid  = st_r.bValid;
    assign s_axi_bresp   = st_r.bResp;
    assign s_axi_arready = st_r.arReady;
    assign s_axi_rvalid  = st_r.rValid;
    assign s_axi_rdata   = st_r.rData;
    assign s_axi_rresp   = st_r.rResp;
    assign padOut        = st_r.padOut;
    assign padOe         = st_r.padOe;
    assign pullEn        = st_r.pullEn;
    assign irq           = st_r.irq;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic fullWr;
    assign fullWr = doWrite && (st_r.wStrb == 4'hf);

    set_output_a: assert property (
        fullWr && st_r.awAddr == pilc_pkg::OFS_OUT_SET |=>
        (st_r.latch & $past(st_r.wData)) == $past(st_r.wData)
        && (st_r.latch & ~$past(st_r.wData)) == ($past(st_r.latch) & ~$past(st_r.wData)))
        else $error("set write did not raise latch bits");

    clear_output_a: assert property (
        fullWr && st_r.awAddr == pilc_pkg::OFS_OUT_CLR |=>
        (st_r.latch & $past(st_r.wData)) == '0
        && (st_r.latch & ~$past(st_r.wData)) == ($past(st_r.latch) & ~$past(st_r.wData)))
        else $error("clear write did not drop latch bits");

    latch_read_a: assert property (
        arFire && s_axi_araddr == pilc_pkg::OFS_OUT_LATCH |=>
        s_axi_rvalid && s_axi_rdata == $past(st_r.latch))
        else $error("latch read returned wrong data");

    direct_write_a: assert property (
        fullWr && st_r.awAddr == pilc_pkg::OFS_OUT_LATCH |=>
        st_r.latch == (($past(st_r.latch) & ~$past(st_r.owr))
                     | ($past(st_r.wData) & $past(st_r.owr))))
        else $error("direct latch write ignored permission");

    pin_read_a: assert property (
        arFire && s_axi_araddr == pilc_pkg::OFS_PIN_LEVEL |=>
        s_axi_rdata == $past(st_r.s2))
        else $error("pin read returned wrong data");

    mask_set_a: assert property (
        fullWr && st_r.awAddr == pilc_pkg::OFS_IRQ_EN |=>
        (st_r.imr & $past(st_r.wData)) == $past(st_r.wData))
        else $error("enable write did not set mask");

    mask_clear_a: assert property (
        fullWr && st_r.awAddr == pilc_pkg::OFS_IRQ_DIS |=>
        (st_r.imr & $past(st_r.wData)) == '0)
        else $error("disable write did not clear mask");

    change_flag_a: assert property (
        (chg != '0) |=> (st_r.isr & $past(chg)) == $past(chg))
        else $error("change not flagged in status");

    status_clear_a: assert property (
        arFire && s_axi_araddr == pilc_pkg::OFS_IRQ_STAT && chg == '0 |=>
        st_r.isr == '0 && s_axi_rdata == $past(st_r.isr))
        else $error("status read did not clear");

    open_drain_a: assert property (
        (padOut & st_r.od) == '0 && (padOe & st_r.od) == (st_r.od & ~st_r.latch))
        else $error("open-drain line driven high");

    push_pull_a: assert property (
        (~padOe & ~st_r.od) == '0 && (padOut & ~st_r.od) == (st_r.latch & ~st_r.od))
        else $error("push-pull line not driven");

    pullup_pol_a: assert property (
        pullEn == ~st_r.puDis)
        else $error("pull-up status polarity wrong");

    irq_out_a: assert property (
        irq == |(st_r.isr & st_r.imr))
        else $error("interrupt output mismatch");

    sample_edge_a: assert property (
        st_r.prime == pilc_pkg::PRIME_DONE && $past(st_r.s2) != st_r.s2 |=>
        (st_r.isr & $past(st_r.s2 ^ st_r.prev)) == $past(st_r.s2 ^ st_r.prev))
        else $error("pin edge missed");

    write_answer_a: assert property (
        doWrite |=> s_axi_bvalid)
        else $error("write answer late");

    wr_latch_c: cover property (fullWr && st_r.awAddr == pilc_pkg::OFS_OUT_LATCH);
    isr_read_c: cover property (arFire && s_axi_araddr == pilc_pkg::OFS_IRQ_STAT && st_r.isr != '0);
    irq_rise_c: cover property ($rose(irq));
    od_low_c:   cover property ((st_r.od & padOe) != '0);

endmodule // pilc_top

//--- bench/pilc_pad_model.sv
// Board-side model of the 32 pads: device drive, board drive, pull-ups
`timescale 1ns/1ps

module pilc_pad_model
(
    // Clock
    input  wire logic        clk,
    // Device side
    input  wire logic [31:0] padOut,
    input  wire logic [31:0] padOe,
    input  wire logic [31:0] pullEn,
    // Board drivers
    input  wire logic [31:0] extDrv,
    input  wire logic [31:0] extEn,
    // Resolved pad level
    output logic      [31:0] padIn
);
    logic [31:0] lastLvl = 32'h0000_0000;

    // Device first, then board, then pull-up; an undriven line keeps moving
    always_comb
    begin
        padIn = (padOe & padOut) | (~padOe & extEn & extDrv)
              | (~padOe & ~extEn & pullEn) | (~padOe & ~extEn & ~pullEn & ~lastLvl);
    end

    // Last level, so a floating line never settles
    always_ff @(posedge clk)
    begin
        lastLvl <= padIn;
    end
endmodule // pilc_pad_model

//--- bench/parallel_io_line_controller_test.sv
// Self-checking testbench of the parallel I/O line controller
`timescale 1ns/1ps

module parallel_io_line_controller_test;
    logic        clk, rst_n, awV, wV, bR, arV, rR, awR, wR, bV, arR, rV, irq;
    logic [6:0]  awA, arA;
    logic [1:0]  bResp, rResp;
    logic [31:0] wD, rD, extDrv, extEn, padIn, padOut, padOe, pullEn;
    logic [31:0] a, b, c, v, lat, st, msk;
    logic [3:0]  wS;
    logic [33:0] expQ[$];
    string       nameQ[$];
    int          mismatches, n_checks;

    // ************************************************************
    // Clock, design and pads
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    pilc_top dut (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(awV), .s_axi_awready(awR),
        .s_axi_awaddr(awA), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_wdata(wD),
        .s_axi_wstrb(wS), .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_bresp(bResp),
        .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_araddr(arA), .s_axi_rvalid(rV),
        .s_axi_rready(rR), .s_axi_rdata(rD), .s_axi_rresp(rResp), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .pullEn(pullEn), .irq(irq));

    pilc_pad_model pads (.clk(clk), .padOut(padOut), .padOe(padOe), .pullEn(pullEn),
        .extDrv(extDrv), .extEn(extEn), .padIn(padIn));

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [6:0] ad, input logic [31:0] d, input logic [3:0] s = 4'hf);
        awA <= ad;
        wD <= d;
        wS <= s;
        awV <= 1'b1;
        wV <= 1'b1;
        bR <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awR) awV <= 1'b0;
            if (wR) wV <= 1'b0;
            if (bV) break;
        end
        chk("write response", {32'h0, pilc_pkg::RESP_OKAY}, {32'h0, bResp});
        bR <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input string nm, input logic [6:0] ad, input logic [31:0] e,
                      input logic [1:0] rs = pilc_pkg::RESP_OKAY);
        expQ.push_back({rs, e});
        nameQ.push_back(nm);
        arA <= ad;
        arV <= 1'b1;
        rR <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arR) arV <= 1'b0;
            if (rV) break;
        end
        rR <= 1'b0;
        @(posedge clk);
    endtask

    // Read data monitor takes the oldest note at each read handshake
    always @(posedge clk)
    begin
        if (rV && rR && expQ.size() > 0)
            chk(nameQ.pop_front(), expQ.pop_front(), {rResp, rD});
        else if (rV && rR)
        begin
            mismatches++;
            $display("unexpected read answer: expected none, seen %h", rD);
        end
    end

    // Watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        {rst_n, awV, wV, bR, arV, rR, awA, arA, wD, wS, extDrv, extEn} = '0;
        mismatches = 0;
        n_checks = 0;
        void'($urandom(32503));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd("latch", pilc_pkg::OFS_OUT_LATCH, pilc_pkg::LATCH_RST);
        rd("mask", pilc_pkg::OFS_IRQ_MASK, pilc_pkg::MASK_RST);
        rd("od status", pilc_pkg::OFS_OD_STAT, pilc_pkg::OD_RST);
        rd("pull status", pilc_pkg::OFS_PU_STAT, pilc_pkg::PUDIS_RST);
        rd("irq status", pilc_pkg::OFS_IRQ_STAT, 32'h0);
        rd("set reg", pilc_pkg::OFS_OUT_SET, 32'h0);
        rd("unmapped", 7'h7c, 32'h0, pilc_pkg::RESP_DECERR);
        // Set then clear with overlapping random words
        a = $urandom;
        b = $urandom;
        wr(pilc_pkg::OFS_OUT_SET, a);
        wr(pilc_pkg::OFS_OUT_CLR, b);
        lat = a & ~b;
        rd("latch", pilc_pkg::OFS_OUT_LATCH, lat);
        chk("pad out", {2'h0, lat}, {2'h0, padOut});
        chk("pad oe", 34'hffff_ffff, {2'h0, padOe});
        rd("pin level", pilc_pkg::OFS_PIN_LEVEL, lat);
        // Direct latch write under partial permission
        c = $urandom;
        v = $urandom;
        wr(pilc_pkg::OFS_OWR_EN, c);
        wr(pilc_pkg::OFS_OUT_LATCH, v);
        st = a | ((lat ^ v) & c);
        lat = (lat & ~c) | (v & c);
        rd("latch", pilc_pkg::OFS_OUT_LATCH, lat);
        // Change interrupt mask, status and request
        a = $urandom;
        b = $urandom;
        wr(pilc_pkg::OFS_IRQ_EN, a);
        wr(pilc_pkg::OFS_IRQ_DIS, b);
        msk = a & ~b;
        rd("mask", pilc_pkg::OFS_IRQ_MASK, msk);
        chk("irq", {33'h0, |(st & msk)}, {33'h0, irq});
        rd("irq status", pilc_pkg::OFS_IRQ_STAT, st);
        rd("irq status", pilc_pkg::OFS_IRQ_STAT, 32'h0);
        chk("irq", 34'h0, {33'h0, irq});
        // Open-drain lines released, board drives them
        wr(pilc_pkg::OFS_OD_EN, 32'hffff_ffff);
        rd("od status", pilc_pkg::OFS_OD_STAT, 32'hffff_ffff);
        wr(pilc_pkg::OFS_OUT_SET, 32'hffff_ffff);
        chk("pad oe", 34'h0, {2'h0, padOe});
        v = $urandom;
        extDrv <= v;
        extEn <= 32'hffff_ffff;
        repeat (4) @(posedge clk);
        rd("pin level", pilc_pkg::OFS_PIN_LEVEL, v);
        st = ~lat | ~v;
        chk("irq", {33'h0, |(st & msk)}, {33'h0, irq});
        rd("irq status", pilc_pkg::OFS_IRQ_STAT, st);
        // Open-drain lines pulled low by the device only
        c = $urandom;
        extEn <= ~c;
        wr(pilc_pkg::OFS_OUT_CLR, c);
        chk("pad oe", {2'h0, c}, {2'h0, padOe});
        chk("pad out", 34'h0, {2'h0, padOut});
        rd("pin level", pilc_pkg::OFS_PIN_LEVEL, v & ~c);
        a = $urandom;
        wr(pilc_pkg::OFS_OD_DIS, a);
        rd("od status", pilc_pkg::OFS_OD_STAT, ~a);
        // Pull-up disable and enable, inverted status
        a = $urandom;
        b = $urandom;
        wr(pilc_pkg::OFS_PU_DIS, a);
        wr(pilc_pkg::OFS_PU_EN, b);
        rd("pull status", pilc_pkg::OFS_PU_STAT, a & ~b);
        chk("pull enable", {2'h0, ~(a & ~b)}, {2'h0, pullEn});
        // Byte strobes: only the two low lanes reach the pull-ups
        wr(pilc_pkg::OFS_PU_DIS, 32'hffff_ffff, 4'h3);
        rd("pull status", pilc_pkg::OFS_PU_STAT, (a & ~b) | 32'h0000_ffff);
        chk("pull enable", {2'h0, ~((a & ~b) | 32'h0000_ffff)}, {2'h0, pullEn});
        // Mid-run reset clears status, latch and pull-up state
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd("irq status", pilc_pkg::OFS_IRQ_STAT, 32'h0);
        rd("latch", pilc_pkg::OFS_OUT_LATCH, pilc_pkg::LATCH_RST);
        chk("pull enable", 34'hffff_ffff, {2'h0, pullEn});
        give_verdict();
    end
endmodule // parallel_io_line_controller_test
